// [rtl/otppp_mem.sv]
// One-time PROM cell array: bits may only go from 1 to 0.
// Assumes callers present one access per cycle; read data are registered.
`timescale 1ns/1ps
`default_nettype none
module otppp_mem
  import otppp_pkg::*;
#(
  parameter int unsigned DEPTH = OTPPP_CELLS,
  parameter int unsigned AW = OTPPP_CELL_W,
  parameter int unsigned DW = OTPPP_DATA_W
)
(
  // Clock
  input wire logic i_clk_sys,
  // Write port
  input wire logic i_burn,
  input wire logic [AW-1:0] i_waddr,
  input wire logic [DW-1:0] i_wdata,
  // Read port
  input wire logic [AW-1:0] i_raddr,
  output logic [DW-1:0] o_rdata
);
  logic [DW-1:0] cells [0:DEPTH-1];

  // ************
  // Blank start
  // ************
  initial
  begin
    for (int i = 0; i < DEPTH; i++)
      cells[i] = OTPPP_BLANK;
  end

  // Programming only clears bits, as a fuse does
  always_ff @(posedge i_clk_sys)
  begin
    if (i_burn)
      cells[i_waddr] <= cells[i_waddr] & i_wdata;
  end

  always_ff @(posedge i_clk_sys)
  begin
    o_rdata <= cells[i_raddr];
  end
endmodule
`default_nettype wire

// [rtl/otppp_top.sv]
// Programming port and address relocation of the one-time PROM.
// Assumes all pins synchronous to i_clk_sys; the programmer keeps the straps.
`timescale 1ns/1ps
`default_nettype none
module otppp_top
  import otppp_pkg::*;
(
  // Clock and reset
  input wire logic i_clk_sys,
  input wire logic i_rst,
  // Mode pins
  input wire logic i_mode_supply,
  input wire logic i_mode_strap_high_pin,
  input wire logic [3:0] i_mode_strap_low_pins,
  input wire logic i_reset_pin,
  // Programmer port
  input wire logic [OTPPP_PADDR_W-1:0] i_prom_addr,
  input wire logic i_chip_sel_n,
  input wire logic i_read_en_n,
  input wire logic i_program_strobe_n,
  input wire logic [OTPPP_DATA_W-1:0] i_prom_data,
  output logic [OTPPP_DATA_W-1:0] o_prom_data,
  output logic o_prom_data_oe_n,
  // Normal-mode fetch port
  input wire logic [OTPPP_CADDR_W-1:0] i_cpu_addr,
  output logic [OTPPP_DATA_W-1:0] o_cpu_data,
  output logic o_cpu_hit,
  // Status
  output logic o_prog_mode,
  output logic o_normal_mode
);
  // ************
  // Mode decode
  // ************
  logic prog_mode;
  logic mode_ok;
  // Straps are the programmer's duty; checked so a bad socket stays inert
  assign mode_ok = i_mode_supply & i_mode_strap_high_pin
                   & ~|i_mode_strap_low_pins & ~i_reset_pin; // RULE6 RULE7

  always_ff @(posedge i_clk_sys)
  begin
    if (i_rst)
    begin
      o_prog_mode <= 1'b0;
      o_normal_mode <= 1'b0;
    end
    else
    begin
      o_prog_mode <= mode_ok;
      o_normal_mode <= ~i_mode_supply; // RULE1
    end
  end
  assign prog_mode = o_prog_mode;

  // ************
  // Address relocation
  // ************
  logic [OTPPP_CELL_W-1:0] p_cell;
  logic p_hit;
  logic [OTPPP_CELL_W-1:0] n_cell;
  logic n_hit;

  always_comb
  begin
    p_cell = '0;
    p_hit = 1'b1;
    if (i_prom_addr >= OTPPP_P_VECT_LO)
      p_cell = i_prom_addr - OTPPP_P_VECT_LO + OTPPP_CELL_VECT; // RULE4
    else if (i_prom_addr >= OTPPP_P_PROG_LO)
      p_cell = i_prom_addr - OTPPP_P_PROG_LO + OTPPP_CELL_PROG; // RULE2
    else if (i_prom_addr >= OTPPP_P_FONT_LO)
      p_cell = i_prom_addr - OTPPP_P_FONT_LO + OTPPP_CELL_FONT; // RULE3
    else
      p_hit = 1'b0; // RULE14
  end

  always_comb
  begin
    n_cell = '0;
    n_hit = 1'b1;
    if (i_cpu_addr >= OTPPP_N_VECT_LO)
      n_cell = OTPPP_CELL_VECT + OTPPP_CELL_W'(i_cpu_addr - OTPPP_N_VECT_LO); // RULE4
    else if (i_cpu_addr >= OTPPP_N_PROG_LO && i_cpu_addr <= OTPPP_N_PROG_HI)
      n_cell = OTPPP_CELL_PROG + OTPPP_CELL_W'(i_cpu_addr - OTPPP_N_PROG_LO); // RULE2
    else if (i_cpu_addr >= OTPPP_N_FONT_LO && i_cpu_addr <= OTPPP_N_FONT_HI)
      n_cell = OTPPP_CELL_FONT + OTPPP_CELL_W'(i_cpu_addr - OTPPP_N_FONT_LO); // RULE3
    else
      n_hit = 1'b0;
  end

  // ************
  // Program strobe
  // ************
  otppp_state_type state;
  logic [OTPPP_CNT_W-1:0] pulse_cnt;
  logic [OTPPP_CELL_W-1:0] burn_addr;
  logic [OTPPP_DATA_W-1:0] burn_data;
  logic write_cond;
  logic burn;

  assign write_cond = prog_mode & ~i_chip_sel_n & i_read_en_n & p_hit; // RULE16
  assign burn = (state == OTPPP_ST_BURN);

  // Burn at strobe release so a glitch shorter than half a pulse is dropped
  always_ff @(posedge i_clk_sys)
  begin
    if (i_rst)
    begin
      state <= OTPPP_ST_IDLE;
    end
    else
    begin
      unique case (state)
        OTPPP_ST_IDLE:
        begin
          if (write_cond && !i_program_strobe_n) // RULE16
            state <= OTPPP_ST_PULSE;
        end
        OTPPP_ST_PULSE:
        begin
          if (!write_cond)
            state <= OTPPP_ST_IDLE;
          else if (i_program_strobe_n)
            state <= (pulse_cnt >= OTPPP_CNT_W'(OTPPP_PULSE_MIN_CYC)) ? OTPPP_ST_BURN : OTPPP_ST_IDLE; // RULE8
        end
        OTPPP_ST_BURN:
          state <= OTPPP_ST_IDLE;
        // Spare code of the two-bit encoding falls back to idle
        default:
          state <= OTPPP_ST_IDLE;
      endcase
    end
  end

  // Pulse length; saturates so an endless strobe cannot wrap into a short one
  always_ff @(posedge i_clk_sys)
  begin
    if (i_rst || state != OTPPP_ST_PULSE)
      pulse_cnt <= '0;
    else if (pulse_cnt != '1)
      pulse_cnt <= pulse_cnt + 1'b1;
  end

  // Address and data taken as the strobe falls, held through the burn
  always_ff @(posedge i_clk_sys)
  begin
    if (i_rst)
    begin
      burn_addr <= '0;
      burn_data <= OTPPP_BLANK;
    end
    else if (state == OTPPP_ST_IDLE && write_cond && !i_program_strobe_n) // RULE16
    begin
      burn_addr <= p_cell;
      burn_data <= i_prom_data;
    end
  end

  // ************
  // Cell array and read path
  // ************
  logic [OTPPP_CELL_W-1:0] raddr;
  logic [OTPPP_DATA_W-1:0] rdata;
  logic p_hit_q;
  logic n_hit_q;

  // One read port shared; programming mode owns it
  assign raddr = prog_mode ? p_cell : n_cell;

  otppp_mem otppp_mem_i (
    .i_clk_sys(i_clk_sys),
    .i_burn(burn),
    .i_waddr(burn_addr),
    .i_wdata(burn_data),
    .i_raddr(raddr),
    .o_rdata(rdata)
  );

  always_ff @(posedge i_clk_sys)
  begin
    if (i_rst)
    begin
      p_hit_q <= 1'b0;
      n_hit_q <= 1'b0;
    end
    else
    begin
      p_hit_q <= p_hit;
      n_hit_q <= n_hit & ~prog_mode;
    end
  end

  // Programmer side outputs
  always_ff @(posedge i_clk_sys)
  begin
    if (i_rst)
    begin
      o_prom_data <= '0;
      o_prom_data_oe_n <= 1'b1;
    end
    else
    begin
      o_prom_data_oe_n <= ~(prog_mode & ~i_chip_sel_n & ~i_read_en_n); // RULE5 RULE15
      o_prom_data <= p_hit_q ? rdata : OTPPP_NO_CELL; // RULE14
    end
  end

  // Fetch side outputs
  always_ff @(posedge i_clk_sys)
  begin
    if (i_rst)
    begin
      o_cpu_data <= '0;
      o_cpu_hit <= 1'b0;
    end
    else
    begin
      o_cpu_data <= n_hit_q ? rdata : OTPPP_BLANK;
      o_cpu_hit <= n_hit_q; // RULE1
    end
  end
endmodule
`default_nettype wire

// [shared/otppp_pkg.sv]
// Constants for the one-time PROM programming port and address relocation.
// Assumes a single 25 MHz system clock and synchronous pin sampling.
// Notes on behaviour
// RULE1: Low mode/supply pin selects normal execution from on-chip memory.
// RULE2: Program area: 04000H-13EFFH normal, 10000H-1FEFFH programming mode.
// RULE3: Font area: 20000H-25FFFH normal, 0A000H-0FFFFH programming mode.
// RULE4: Vector table: FFF00H-FFFFFH normal, 1FF00H-1FFFFH programming mode.
// RULE5: Programming mode: chip select and read enable are active low.
// RULE6: Programmer holds high strap pin high throughout programming session.
// RULE7: Programmer holds low strap pins and reset low throughout session.
// RULE8: Programmer writes a byte with one 0.1 ms strobe pulse.
// RULE9: Programmer verifies each byte, retrying up to 25 attempts.
// RULE10: After a good verify the programmer moves to the next address.
// RULE11: Programmer finishes with a read-back pass over the whole range.
// RULE12: Programmer covers programming addresses 0A000H through 1FFFFH.
// RULE13: Unused locations are filled with FFH or skipped by the programmer.
// RULE14: No signature read mode; identification cycles carry no meaning.
// RULE15: Data bus driven only while chip select and read enable are low.
// RULE16: Strobe active low; write needs chip select low, read enable high.
package otppp_pkg;
  localparam int unsigned OTPPP_PADDR_W = 17;
  localparam int unsigned OTPPP_CADDR_W = 20;
  localparam int unsigned OTPPP_CELL_W = 17;
  localparam int unsigned OTPPP_DATA_W = 8;
  // Programming-mode windows
  localparam logic [16:0] OTPPP_P_FONT_LO = 17'h0A000;
  localparam logic [16:0] OTPPP_P_FONT_HI = 17'h0FFFF;
  localparam logic [16:0] OTPPP_P_PROG_LO = 17'h10000;
  localparam logic [16:0] OTPPP_P_PROG_HI = 17'h1FEFF;
  localparam logic [16:0] OTPPP_P_VECT_LO = 17'h1FF00;
  // Normal-mode windows
  localparam logic [19:0] OTPPP_N_PROG_LO = 20'h04000;
  localparam logic [19:0] OTPPP_N_PROG_HI = 20'h13EFF;
  localparam logic [19:0] OTPPP_N_FONT_LO = 20'h20000;
  localparam logic [19:0] OTPPP_N_FONT_HI = 20'h25FFF;
  localparam logic [19:0] OTPPP_N_VECT_LO = 20'hFFF00;
  // Cell index bases: font 0..5FFF, program 6000..15EFF, vector 15F00..15FFF
  localparam logic [16:0] OTPPP_CELL_FONT = 17'h00000;
  localparam logic [16:0] OTPPP_CELL_PROG = 17'h06000;
  localparam logic [16:0] OTPPP_CELL_VECT = 17'h15F00;
  localparam int unsigned OTPPP_CELLS = 32'h00016000;
  localparam logic [7:0] OTPPP_BLANK = 8'hFF;
  localparam logic [7:0] OTPPP_NO_CELL = 8'hFF;
  // Strobe timing
  localparam int unsigned OTPPP_CLK_MHZ = 25;
  localparam int unsigned OTPPP_PULSE_NS = 100000;
  localparam int unsigned OTPPP_PULSE_MIN_CYC = OTPPP_PULSE_NS * OTPPP_CLK_MHZ / 1000 / 2;
  localparam int unsigned OTPPP_CNT_W = 16;
  typedef enum logic [1:0] {OTPPP_ST_IDLE, OTPPP_ST_PULSE, OTPPP_ST_BURN} otppp_state_type;
endpackage

// [sim/otppp_prog_model.sv]
// Behavioural PROM programmer.
// Assumes the bench resolves the shared data bus.
`timescale 1ns/1ps
`default_nettype none
module otppp_prog_model
(
  // Clock
  input wire logic i_clk_sys,
  // Programmer pins
  output logic [16:0] o_addr,
  output logic o_cs_n,
  output logic o_re_n,
  output logic o_pgm_n,
  output logic [7:0] o_data,
  output logic o_smp
);
  // ****
  // Bus and tasks
  // ****
  logic [7:0] wd = 8'h00;
  logic drv = 1'b0;
  // Released bus shows the inverse of the last byte
  assign o_data = drv ? wd : ~wd;
  initial
  begin
    o_addr = 17'h00000;
    o_cs_n = 1'b1;
    o_re_n = 1'b1;
    o_pgm_n = 1'b1;
    o_smp = 1'b0;
  end
  task automatic wr(input logic [16:0] a, input logic [7:0] d, input int n);
    @(negedge i_clk_sys);
    o_addr = a;
    wd = d;
    drv = 1'b1;
    o_cs_n = 1'b0;
    @(negedge i_clk_sys);
    o_pgm_n = 1'b0;
    repeat (n) @(negedge i_clk_sys);
    o_pgm_n = 1'b1;
    repeat (3) @(negedge i_clk_sys);
    drv = 1'b0;
    o_cs_n = 1'b1;
  endtask
  task automatic rd(input logic [16:0] a);
    @(negedge i_clk_sys);
    o_addr = a;
    o_cs_n = 1'b0;
    o_re_n = 1'b0;
    repeat (3) @(negedge i_clk_sys);
    o_smp = 1'b1;
    @(negedge i_clk_sys);
    o_smp = 1'b0;
    o_cs_n = 1'b1;
    o_re_n = 1'b1;
  endtask
endmodule
`default_nettype wire

// [sim/otppp_top_sva.sv]
// Checker for the PROM port and fetch map.
// Assumes it is bound onto otppp_top.
`timescale 1ns/1ps
`default_nettype none
module otppp_sva
  import otppp_pkg::*;
(
  // Watched pins
  input wire logic i_clk_sys, i_rst, i_mode_supply, i_mode_strap_high_pin, i_reset_pin,
  input wire logic i_chip_sel_n, i_read_en_n, o_prom_data_oe_n, o_cpu_hit, o_prog_mode, o_normal_mode,
  input wire logic [3:0] i_mode_strap_low_pins,
  input wire logic [16:0] i_prom_addr,
  input wire logic [7:0] o_prom_data, o_cpu_data,
  input wire logic [19:0] i_cpu_addr
);
  // ****
  // Helpers
  // ****
  logic [2:0] age;
  logic rd;
  logic win;
  assign rd = o_prog_mode & ~i_chip_sel_n & ~i_read_en_n;
  assign win = (i_cpu_addr >= OTPPP_N_PROG_LO && i_cpu_addr <= OTPPP_N_PROG_HI) ||
    (i_cpu_addr >= OTPPP_N_FONT_LO && i_cpu_addr <= OTPPP_N_FONT_HI) || i_cpu_addr >= OTPPP_N_VECT_LO;
  // Pipelines hold reset values for a few edges
  always_ff @(posedge i_clk_sys)
  begin
    if (i_rst)
      age <= 3'h0;
    else if (age != 3'h7)
      age <= age + 3'h1;
  end
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (i_rst);
  // ****
  // Assertions
  // ****
  a_prog_mode_straps: assert property (age > 0 |-> o_prog_mode == $past(i_mode_supply &
    i_mode_strap_high_pin & ~i_reset_pin & (i_mode_strap_low_pins == 4'h0))) else $error("mode");
  a_normal_supply: assert property (age > 0 |-> o_normal_mode == !$past(i_mode_supply))
    else $error("normal");
  a_oe_on_read: assert property (age > 0 |-> o_prom_data_oe_n == !$past(rd))
    else $error("oe");
  a_idle_release: assert property (i_chip_sel_n |=> o_prom_data_oe_n) else $error("idle");
  a_unmapped_ff: assert property (age > 3 && $past(rd) && $past(rd, 2) &&
    $past(i_prom_addr, 2) < OTPPP_P_FONT_LO |-> o_prom_data == OTPPP_NO_CELL) else $error("unmap");
  a_hit_window: assert property ((age > 3 && !o_prog_mode)[*4] |-> o_cpu_hit == $past(win, 2))
    else $error("hit");
  a_no_hit_prog: assert property (o_prog_mode[*4] |-> !o_cpu_hit) else $error("phit");
  a_fetch_ff: assert property (age > 3 && !$past(win, 2) |-> o_cpu_data == OTPPP_NO_CELL)
    else $error("fetch");
endmodule
bind otppp_top otppp_sva otppp_sva_i (.*);
`default_nettype wire

// [sim/otppp_top_tb_top.sv]
// Bench for the PROM port: program, verify, refetch.
// Assumes the programmer model drives the port.
`timescale 1ns/1ps
`default_nettype none
module otppp_top_tb_top;
  import otppp_pkg::*;
  // ****
  // Signals
  // ****
  logic i_clk_sys = 1'b0, i_rst = 1'b1, i_mode_supply = 1'b1, i_mode_strap_high_pin = 1'b1, i_reset_pin = 1'b0;
  logic [3:0] i_mode_strap_low_pins = 4'h0;
  logic [19:0] i_cpu_addr = 20'h00000;
  logic [16:0] i_prom_addr;
  logic i_chip_sel_n, i_read_en_n, i_program_strobe_n, psmp, fsmp = 1'b0;
  logic o_prom_data_oe_n, o_cpu_hit, o_prog_mode, o_normal_mode;
  logic [7:0] mdata, i_prom_data, o_prom_data, o_cpu_data, lf = 8'h0F;
  logic [7:0] d [4];
  logic [7:0] q [$];
  int failures = 0, checks = 0;
  localparam logic [16:0] PA [4] = '{17'h0A000, 17'h10000, 17'h1FEFF, 17'h1FFFF};
  localparam logic [19:0] NA [4] = '{20'h20000, 20'h04000, 20'h13EFF, 20'hFFFFF};
  assign i_prom_data = o_prom_data_oe_n ? mdata : o_prom_data;
  always #20 i_clk_sys = ~i_clk_sys;
  otppp_top otppp_top_i (.*);
  otppp_prog_model otppp_prog_model_i (.i_clk_sys(i_clk_sys), .o_addr(i_prom_addr), .o_cs_n(i_chip_sel_n),
    .o_re_n(i_read_en_n), .o_pgm_n(i_program_strobe_n), .o_data(mdata), .o_smp(psmp));
  // ****
  // Tasks
  // ****
  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
    checks++;
    if (s !== e)
    begin
      failures++;
      $display("[ERR] %s exp %h seen %h", n, e, s);
    end
  endtask
  task automatic wrap_up();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic fetch(input logic [19:0] a, input logic [7:0] e);
    @(negedge i_clk_sys);
    i_cpu_addr = a;
    q.push_back(e);
    repeat (3) @(negedge i_clk_sys);
    fsmp = 1'b1;
    @(negedge i_clk_sys);
    fsmp = 1'b0;
  endtask
  // Oldest note against each result
  always @(posedge i_clk_sys)
    if (psmp === 1'b1 || fsmp === 1'b1)
      chk("data", fsmp ? o_cpu_data : o_prom_data, q.pop_front());
  initial
  begin
    repeat (50000) @(posedge i_clk_sys);
    failures++;
    wrap_up();
  end
  // ****
  // Sequence
  // ****
  initial
  begin
    repeat (4) @(negedge i_clk_sys);
    i_rst = 1'b0;
    repeat (2) @(negedge i_clk_sys);
    chk("prog", {7'h00, o_prog_mode}, 8'h01);
    for (int k = 0; k < 4; k++)
    begin
      lf = lfsr(lf);
      d[k] = lf;
      otppp_prog_model_i.wr(PA[k], lf, 2500);
      chk("oe", {7'h00, o_prom_data_oe_n}, 8'h01);
      q.push_back(lf);
      otppp_prog_model_i.rd(PA[k]);
    end
    otppp_prog_model_i.wr(17'h0C000, OTPPP_BLANK, 2500);
    q.push_back(OTPPP_BLANK);
    otppp_prog_model_i.rd(17'h0C000);
    otppp_prog_model_i.wr(17'h0FFFF, 8'h00, 100);
    q.push_back(OTPPP_BLANK);
    otppp_prog_model_i.rd(17'h0FFFF);
    q.push_back(OTPPP_NO_CELL);
    otppp_prog_model_i.rd(17'h09FFF);
    for (int k = 0; k < 4; k++)
    begin
      q.push_back(d[k]);
      otppp_prog_model_i.rd(PA[k]);
      chk("oe", {7'h00, o_prom_data_oe_n}, 8'h00);
    end
    i_mode_supply = 1'b0;
    repeat (2) @(negedge i_clk_sys);
    chk("norm", {7'h00, o_normal_mode}, 8'h01);
    for (int k = 0; k < 4; k++)
    begin
      fetch(NA[k], d[k]);
      chk("hit", {7'h00, o_cpu_hit}, 8'h01);
    end
    fetch(20'h13F00, OTPPP_NO_CELL);
    chk("hit", {7'h00, o_cpu_hit}, 8'h00);
    i_mode_supply = 1'b1;
    i_mode_strap_low_pins = lf[3:0] | 4'h1;
    repeat (2) @(negedge i_clk_sys);
    chk("strap", {7'h00, o_prog_mode}, 8'h00);
    wrap_up();
  end
endmodule
`default_nettype wire
